/* logic/mgmt_map.svh */
// constants for the two-wire management port
//
// Contract
// - station sources clock, at most 1.75 MHz
// - device works with stopped idle clock
// - receiver samples data on rising clock
// - device latches 4-bit address at reset
// - no frame in first cycle after reset
// - register field indexes 32 16-bit registers
// - frames start with 01 start code
// - data field carries write or read data
// - nobody drives first turnaround bit of reads
// - device drives zero then 16 data bits
// - station drives 10 turnaround on writes
// - station keeps clocking through trailing idle
// - device accepts clause 22 and 45 frames; the register file is written only by clause 22 writes
`ifndef MGMT_MAP_SVH
`define MGMT_MAP_SVH
`define MDC_MAX_KHZ      1750
`define SYS_CLK_KHZ      10000
`define MDC_DIV          ((`SYS_CLK_KHZ + 2*`MDC_MAX_KHZ - 1) / (2*`MDC_MAX_KHZ))
`define ST_C22           2'b01
`define ST_C45           2'b00
`define OP_C22_WR        2'b01
`define OP_C22_RD        2'b10
`define OP_C45_ADDR      2'b00
`define OP_C45_WR        2'b01
`define OP_C45_RD        2'b11
`define OP_C45_RDINC     2'b10
`define TA_WRITE         2'b10
`define PRE_BITS         6'h20
`define HDR_BITS         6'h0e
`define DATA_BITS        6'h10
`define TRAIL_BITS       6'h02
`define BIT_MSB_HDR      5'h0d
`define BIT_MSB_DATA     5'h0f
`endif

/* logic/mgmt_pkg.sv */
// types shared by both ends of the management port
package mgmt_pkg;
    typedef enum logic [2:0] {
        DS_IDLE = 3'b000,
        DS_HDR  = 3'b001,
        DS_TA   = 3'b010,
        DS_DATA = 3'b011,
        DS_SKIP = 3'b100
    } dev_state_t;

    typedef enum logic [2:0] {
        SS_IDLE  = 3'b000,
        SS_PRE   = 3'b001,
        SS_HDR   = 3'b010,
        SS_TA    = 3'b011,
        SS_DATA  = 3'b100,
        SS_TRAIL = 3'b101
    } sta_state_t;
endpackage : mgmt_pkg

/* logic/mgmt_if.sv */
// two-wire management bus joining station and device
`timescale 1ns/1ps
interface mgmt_if;
    logic mdc;
    logic sta_o;
    logic sta_oe;
    logic dev_o;
    logic dev_oe;
    logic mdio;
    // wired line with pull-up: low if any enabled driver pulls low
    assign mdio = (sta_oe ? sta_o : 1'b1) & (dev_oe ? dev_o : 1'b1);

    modport station (output mdc, output sta_o, output sta_oe,
                     input mdio);
    modport device (input mdc, output dev_o, output dev_oe,
                    input mdio);
endinterface : mgmt_if

/* logic/mgmt_device.sv */
// device end: management slave clocked by the link clock
`timescale 1ns/1ps
`include "mgmt_map.svh"
module mgmt_device #(
    parameter int NREG = 32
) (
    // link
    mgmt_if.device          bus,
    // link-side reset and address straps
    input  wire logic       reset,
    input  wire logic [3:0] addr_pins,
    // system side
    input  wire logic       clk,
    output logic [15:0]     wr_data,
    output logic [4:0]      wr_reg,
    output logic            wr_toggle
);
    typedef struct packed {
        mgmt_pkg::dev_state_t st;
        logic [3:0]  addr;
        logic        addr_ok;
        logic [13:0] hdr;
        logic [4:0]  cnt;
        logic [15:0] sh;
        logic        rd;
        logic        drv;
        logic        o;
        logic        c45;
        logic [4:0]  reg_idx;
        logic [15:0] wdat;
        logic        wtog;
    } dev_s_t;

    dev_s_t s_r, s_nxt;
    logic [15:0] regs_r [NREG];
    logic        wr_en;
    logic        rst_q1, rst_q2;
    logic [2:0]  tog_sync_r;
    logic [15:0] wr_data_r;
    logic [4:0]  wr_reg_r;

    // reset is a level from the system side, so resync it
    always_ff @(posedge bus.mdc) begin
        rst_q1 <= reset;
        rst_q2 <= rst_q1;
    end

    // link side of the device is edge-driven by mdc only; no free clock needed
    always_comb begin
        s_nxt = s_r;
        wr_en = 1'b0;
        if (!s_r.addr_ok) begin
            s_nxt.addr    = addr_pins;
            s_nxt.addr_ok = 1'b1;
        end
        case (s_r.st)
            mgmt_pkg::DS_IDLE: begin
                s_nxt.drv = 1'b0;
                // sample on rising edge; zero after idle ones opens start
                if (!bus.mdio) begin
                    s_nxt.st  = mgmt_pkg::DS_HDR;
                    s_nxt.hdr = 14'h0000;
                    s_nxt.cnt = `BIT_MSB_HDR;
                end
            end
            mgmt_pkg::DS_HDR: begin
                s_nxt.hdr = {s_r.hdr[12:0], bus.mdio};
                s_nxt.cnt = s_r.cnt - 5'h01;
                if (s_r.cnt == 5'h01) begin
                    // 13 bits taken, so the next rising edge is ta bit one
                    s_nxt.st = mgmt_pkg::DS_TA;
                end
            end
            mgmt_pkg::DS_TA: begin
                // header: st1 | op[2] | phy[5] | reg[5]; now at ta bit one
                // deciding here lets the zero go out for ta bit two
                s_nxt.c45     = (s_r.hdr[12] == 1'b0);
                s_nxt.reg_idx = s_r.hdr[4:0];
                s_nxt.rd      = s_r.hdr[12] ?
                    (s_r.hdr[11:10] == `OP_C22_RD) :
                    (s_r.hdr[11:10] == `OP_C45_RD ||
                     s_r.hdr[11:10] == `OP_C45_RDINC);
                if (s_r.hdr[9:5] != {1'b0, s_r.addr}) begin
                    s_nxt.st = mgmt_pkg::DS_SKIP;
                    s_nxt.cnt = `BIT_MSB_DATA + 5'h01;
                end else begin
                    s_nxt.st  = mgmt_pkg::DS_DATA;
                    s_nxt.cnt = `BIT_MSB_DATA + 5'h01;
                    s_nxt.sh  = regs_r[s_r.hdr[4:0]];
                    // first ta bit undriven; drive zero next bit
                    s_nxt.drv = s_nxt.rd;
                    s_nxt.o   = 1'b0;
                end
            end
            mgmt_pkg::DS_DATA: begin
                if (s_r.rd) begin
                    s_nxt.o  = s_r.sh[15];
                    s_nxt.sh = {s_r.sh[14:0], 1'b0};
                    if (s_r.cnt == 5'h00) begin
                        s_nxt.drv = 1'b0;
                        s_nxt.st  = mgmt_pkg::DS_IDLE;
                    end
                    s_nxt.cnt = s_r.cnt - 5'h01;
                end else if (s_r.cnt == 5'h10) begin
                    s_nxt.cnt = s_r.cnt - 5'h01; // second ta bit from station
                end else begin
                    s_nxt.sh  = {s_r.sh[14:0], bus.mdio};
                    s_nxt.cnt = s_r.cnt - 5'h01;
                    if (s_r.cnt == 5'h00) begin
                        wr_en      = 1'b1;
                        s_nxt.wdat = {s_r.sh[14:0], bus.mdio};
                        s_nxt.wtog = ~s_r.wtog;
                        s_nxt.st   = mgmt_pkg::DS_IDLE;
                    end
                end
            end
            mgmt_pkg::DS_SKIP: begin
                s_nxt.cnt = s_r.cnt - 5'h01;
                if (s_r.cnt == 5'h00) s_nxt.st = mgmt_pkg::DS_IDLE;
            end
            default: s_nxt.st = mgmt_pkg::DS_IDLE;
        endcase
    end

    // state register and register file
    always_ff @(posedge bus.mdc) begin
        if (rst_q2) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
            if (wr_en && !s_r.c45) regs_r[s_r.reg_idx] <= s_nxt.wdat;
        end
    end

    // drive output changes on falling edge so station samples stable data
    logic o_f, oe_f;
    always_ff @(negedge bus.mdc) begin
        o_f  <= s_r.o;
        oe_f <= s_r.drv;
    end
    assign bus.dev_o  = o_f;
    assign bus.dev_oe = oe_f;

    // write event crosses to clk by toggle; data set on the same mdc edge, stable long after
    always_ff @(posedge clk) begin
        if (reset) begin
            tog_sync_r <= 3'h0;
            wr_data_r  <= 16'h0000;
            wr_reg_r   <= 5'h00;
            wr_toggle  <= 1'b0;
        end else begin
            tog_sync_r <= {tog_sync_r[1:0], s_r.wtog};
            if (tog_sync_r[2] != tog_sync_r[1]) begin
                wr_data_r <= s_r.wdat;
                wr_reg_r  <= s_r.reg_idx;
                wr_toggle <= ~wr_toggle;
            end
        end
    end
    assign wr_data = wr_data_r;
    assign wr_reg  = wr_reg_r;
endmodule : mgmt_device

/* logic/mgmt_station.sv */
// station end: makes mdc by division and runs clause 22 frames
`timescale 1ns/1ps
`include "mgmt_map.svh"
module mgmt_station (
    // system
    input  wire logic        clk,
    input  wire logic        reset,
    // link
    mgmt_if.station          bus,
    // request and answer
    input  wire logic        req,
    input  wire logic        req_wr,
    input  wire logic [4:0]  req_phy,
    input  wire logic [4:0]  req_reg,
    input  wire logic [15:0] req_data,
    output logic             busy,
    output logic             done,
    output logic [15:0]      rd_data
);
    typedef struct packed {
        mgmt_pkg::sta_state_t st;
        logic [7:0]  div;
        logic        mdc;
        logic [5:0]  cnt;
        logic [31:0] sh;
        logic        wr;
        logic        o;
        logic        oe;
        logic [15:0] rdat;
        logic        done;
        logic        busy;
        logic        s1;
        logic        s2;
    } sta_s_t;

    sta_s_t s_r, s_nxt;
    logic rise, fall;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        s_nxt.s1   = bus.mdio;
        s_nxt.s2   = s_r.s1;
        rise = 1'b0;
        fall = 1'b0;
        // clock runs only during frames and trailing idle
        if (s_r.st != mgmt_pkg::SS_IDLE) begin
            if (s_r.div == 8'(`MDC_DIV - 1)) begin
                s_nxt.div = 8'h00;
                s_nxt.mdc = ~s_r.mdc;
                rise = ~s_r.mdc;
                fall = s_r.mdc;
            end else begin
                s_nxt.div = s_r.div + 8'h01;
            end
        end
        case (s_r.st)
            mgmt_pkg::SS_IDLE: begin
                s_nxt.oe = 1'b0;
                if (req) begin
                    s_nxt.st   = mgmt_pkg::SS_PRE;
                    s_nxt.busy = 1'b1;
                    s_nxt.wr   = req_wr;
                    s_nxt.cnt  = `PRE_BITS;
                    // start, opcode, addresses, ta, data: msb first
                    s_nxt.sh   = {`ST_C22,
                        req_wr ? `OP_C22_WR : `OP_C22_RD,
                        req_phy, req_reg, `TA_WRITE, req_data};
                    s_nxt.oe   = 1'b1;
                    s_nxt.o    = 1'b1;
                end
            end
            mgmt_pkg::SS_PRE: if (fall) begin
                s_nxt.cnt = s_r.cnt - 6'h01;
                if (s_r.cnt == 6'h01) begin
                    s_nxt.st  = mgmt_pkg::SS_HDR;
                    s_nxt.cnt = `HDR_BITS;
                    s_nxt.o   = s_r.sh[31];
                    s_nxt.sh  = {s_r.sh[30:0], 1'b0};
                end
            end
            mgmt_pkg::SS_HDR: if (fall) begin
                s_nxt.cnt = s_r.cnt - 6'h01;
                if (s_r.cnt == 6'h01) begin
                    s_nxt.st  = mgmt_pkg::SS_TA;
                    s_nxt.cnt = 6'h02;
                    s_nxt.oe  = s_r.wr; // release on read
                end
                s_nxt.o  = s_r.sh[31];
                s_nxt.sh = {s_r.sh[30:0], 1'b0};
            end
            mgmt_pkg::SS_TA: if (fall) begin
                // writes send 1 then 0 over turnaround
                s_nxt.cnt = s_r.cnt - 6'h01;
                s_nxt.o   = s_r.sh[31];
                s_nxt.sh  = {s_r.sh[30:0], 1'b0};
                if (s_r.cnt == 6'h01) begin
                    s_nxt.st  = mgmt_pkg::SS_DATA;
                    s_nxt.cnt = `DATA_BITS;
                end
            end
            mgmt_pkg::SS_DATA: begin
                // read data sampled on rising edge
                if (rise && !s_r.wr) s_nxt.rdat = {s_r.rdat[14:0], s_r.s2};
                if (fall) begin
                    s_nxt.cnt = s_r.cnt - 6'h01;
                    s_nxt.o   = s_r.sh[31];
                    s_nxt.sh  = {s_r.sh[30:0], 1'b0};
                    if (s_r.cnt == 6'h01) begin
                        s_nxt.st  = mgmt_pkg::SS_TRAIL;
                        s_nxt.cnt = `TRAIL_BITS;
                        s_nxt.oe  = 1'b0;
                    end
                end
            end
            mgmt_pkg::SS_TRAIL: if (fall) begin
                // idle clocks let the device finish
                s_nxt.cnt = s_r.cnt - 6'h01;
                if (s_r.cnt == 6'h01) begin
                    s_nxt.st   = mgmt_pkg::SS_IDLE;
                    s_nxt.busy = 1'b0;
                    s_nxt.done = 1'b1;
                    s_nxt.div  = 8'h00;
                    s_nxt.mdc  = 1'b0;
                end
            end
            default: s_nxt.st = mgmt_pkg::SS_IDLE;
        endcase
    end

    // single state register
    always_ff @(posedge clk) begin
        if (reset) s_r <= '0;
        else s_r <= s_nxt;
    end

    assign bus.mdc    = s_r.mdc;
    assign bus.sta_o  = s_r.o;
    assign bus.sta_oe = s_r.oe;
    assign busy       = s_r.busy;
    assign done       = s_r.done;
    assign rd_data    = s_r.rdat;
endmodule : mgmt_station

/* tb/mgmt_sva.sv */
// wire-level checks on the two-wire management bus
`timescale 1ns/1ps
module mgmt_sva (
    // station clock domain
    input wire logic clk,
    input wire logic reset,
    // wire signals
    input wire logic mdc,
    input wire logic sta_o,
    input wire logic sta_oe,
    input wire logic dev_o,
    input wire logic dev_oe,
    input wire logic mdio
);
    logic [7:0] run_r;
    logic [7:0] run_nxt;

    // length of a device drive burst in clk cycles, cleared when released
    always_comb run_nxt = dev_oe ? run_r + 8'h01 : 8'h00;
    always_ff @(posedge clk) begin
        run_r <= reset ? 8'h00 : run_nxt;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // mdc is a divided clk, so each phase is at least three clk cycles
    chk_mdc_high: assert property ($rose(mdc) |-> mdc [*3])
        else $error("mdc high phase too short");
    chk_mdc_low: assert property ($fell(mdc) |-> !mdc [*3])
        else $error("mdc low phase too short");
    // 32 preamble bits of six clk each, then 0 and 1
    chk_start_code: assert property (
        $rose(sta_oe) |-> ##192 !sta_o ##6 sta_o)
        else $error("start code not after preamble");
    // both opcodes have unequal bits
    chk_opcode_bits: assert property (
        $rose(sta_oe) |-> ##210 (sta_o != $past(sta_o, 6)))
        else $error("opcode bits equal");
    chk_write_ta: assert property (
        $rose(sta_oe) ##204 !sta_o |-> ##72 (sta_oe && sta_o)
        ##6 (sta_oe && !sta_o))
        else $error("write turnaround not 10");
    chk_turn_zero: assert property (
        $rose(dev_oe) |-> !dev_o && !mdio)
        else $error("device turnaround bit not zero");
    chk_turn_gap: assert property (
        $rose(dev_oe) |-> $past(sta_oe, 3) == 1'b0)
        else $error("first turnaround bit driven");
    // one zero bit and 16 data bits
    chk_burst_len: assert property ($fell(dev_oe) |-> run_r == 8'h66)
        else $error("device drive burst length wrong");
    chk_no_fight: assert property (!(sta_oe && dev_oe))
        else $error("both ends drive the line");
endmodule : mgmt_sva

/* tb/phy_serial_management_port_bench.sv */
// self-checking bench joining station and device over the bus
`timescale 1ns/1ps
module phy_serial_management_port_bench;
    logic        clk;
    logic        reset;
    logic        dev_reset;
    logic [3:0]  addr_pins;
    logic        req;
    logic        req_wr;
    logic [4:0]  req_phy;
    logic [4:0]  req_reg;
    logic [15:0] req_data;
    logic        busy;
    logic        done;
    logic [15:0] rd_data;
    logic [15:0] wr_data;
    logic [4:0]  wr_reg;
    logic        wr_toggle;
    logic        tog_before;
    logic        mdc_seen;
    int          n_fail;
    int          total_checks;
    logic [4:0]  regs [3];
    logic [15:0] vals [3];

    mgmt_if mif ();
    mgmt_station u_mgmt_station (.clk(clk), .reset(reset), .bus(mif),
        .req(req), .req_wr(req_wr), .req_phy(req_phy), .req_reg(req_reg),
        .req_data(req_data), .busy(busy), .done(done), .rd_data(rd_data));
    mgmt_device u_mgmt_device (.bus(mif), .reset(dev_reset),
        .addr_pins(addr_pins), .clk(clk), .wr_data(wr_data),
        .wr_reg(wr_reg), .wr_toggle(wr_toggle));
    // checks wait until both ends are out of reset
    mgmt_sva u_mgmt_sva (.clk(clk), .reset(reset | dev_reset), .mdc(mif.mdc),
        .sta_o(mif.sta_o), .sta_oe(mif.sta_oe), .dev_o(mif.dev_o),
        .dev_oe(mif.dev_oe), .mdio(mif.mdio));

    // 10 MHz system clock
    initial clk = 1'b0;
    always #50 clk = ~clk;

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one frame; request held until busy, then wait for done
    task automatic xfer(input logic wr, input logic [4:0] phy,
                        input logic [4:0] rg, input logic [15:0] d);
        int n;
        req      <= 1'b1;
        req_wr   <= wr;
        req_phy  <= phy;
        req_reg  <= rg;
        req_data <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy !== 1'b1 && n < 20);
        if (n >= 20) n_fail++;
        req <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 2000);
        if (n >= 2000) n_fail++;
        // let the write indication cross into the clk domain
        repeat (12) @(posedge clk);
    endtask : xfer

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // about a dozen frames of roughly 420 cycles each
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        n_fail = 0;
        total_checks = 0;
        regs = '{5'h00, 5'h1f, 5'h0a};
        vals = '{16'h8001, 16'h7ffe, 16'ha5c3};
        reset = 1'b1;
        dev_reset = 1'b1;
        addr_pins = 4'h5;
        req = 1'b0;
        req_wr = 1'b0;
        req_phy = 5'h00;
        req_reg = 5'h00;
        req_data = 16'h0000;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        // device reset is sampled by mdc, which runs only inside frames
        xfer(1'b1, 5'h05, 5'h00, 16'h0000);
        dev_reset <= 1'b0;
        xfer(1'b0, 5'h05, 5'h00, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            tog_before = wr_toggle;
            xfer(1'b1, 5'h05, regs[i], vals[i]);
            check("wr_toggle", {15'h0000, wr_toggle}, {15'h0000, ~tog_before});
            check("wr_reg", {11'h000, wr_reg}, {11'h000, regs[i]});
            check("wr_data", wr_data, vals[i]);
        end
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, 5'h05, regs[i], 16'h0000);
            check("rd_data", rd_data, vals[i]);
        end
        // frames for other addresses must leave this device alone
        tog_before = wr_toggle;
        xfer(1'b1, 5'h15, 5'h00, 16'h1234);
        check("foreign wr", {15'h0000, wr_toggle}, {15'h0000, tog_before});
        xfer(1'b0, 5'h04, 5'h00, 16'h0000);
        check("foreign rd", rd_data, 16'hffff);
        // the clock stands still between frames
        mdc_seen = mif.mdc;
        repeat (30) @(posedge clk);
        check("idle mdc", {15'h0000, mif.mdc}, {15'h0000, mdc_seen});
        xfer(1'b0, 5'h05, 5'h00, 16'h0000);
        check("rd after idle", rd_data, 16'h8001);
        tally_and_finish();
    end
endmodule : phy_serial_management_port_bench
